// *** verilog/csf_map.svh ***
/*
  Register offset, field positions, reset value and BCD correction constants
  of the CPU condition status flag logic.
  Assumes it is included by bare name from the address checker, the flag unit and the bench.
*/
`ifndef CSF_MAP_SVH
`define CSF_MAP_SVH

// ********************************
// register offset and reset
// ********************************
`define CSF_STATUS_OFFSET 8'hD5
`define CSF_STATUS_RESET 8'h00

// ********************************
// field positions
// ********************************
`define CSF_POS_CARRY 7
`define CSF_POS_ZERO 6
`define CSF_POS_SIGN 5
`define CSF_POS_OVF 4
`define CSF_POS_DEC 3
`define CSF_POS_HALF 2
`define CSF_POS_FIS 1
`define CSF_POS_BANK 0

// ********************************
// decimal adjust constants
// ********************************
`define CSF_BCD_DIGIT_MAX 4'h9
`define CSF_BCD_BYTE_MAX 8'h99
`define CSF_BCD_CORR_DIGIT 4'h6

`endif

// *** verilog/csf_pkg.sv ***
/*
  Types shared by the status flag logic: flag layout, operation codes,
  register access request and addressing modes.
  Assumes csf_map.svh is on the include path.
*/
package csf_pkg;

  // flag byte, carry in the msb as laid out in the status register
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic fast_irq_active_bit;
    logic ba;
  } csf_flags_t;

  typedef enum logic [4:0] {
    CSF_OP_ADD, CSF_OP_ADC, CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CP,
    CSF_OP_INC, CSF_OP_DEC,
    CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_COM,
    CSF_OP_RL, CSF_OP_RLC, CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA,
    CSF_OP_TEST,
    CSF_OP_DA,
    CSF_OP_SET_CARRY, CSF_OP_CLEAR_CARRY, CSF_OP_INVERT_CARRY,
    CSF_OP_BANK_ZERO, CSF_OP_BANK_ONE,
    CSF_OP_FAST_ENTER, CSF_OP_INTERRUPT_RETURN_OP
  } csf_op_t;

  // register file port as seen by the status register
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csf_reg_req_t;

  typedef enum logic [2:0] {
    CSF_AM_PAIR_REG, CSF_AM_PAIR_WORK, CSF_AM_RELATIVE,
    CSF_AM_INDEX_SHORT, CSF_AM_INDEX_LONG
  } csf_amode_t;

  typedef struct packed {
    csf_amode_t mode;
    logic [15:0] base;
    logic [15:0] offs;
  } csf_addr_req_t;

endpackage

// *** verilog/csf_addr_calc.sv ***
/*
  Operand address checker and effective address adder for register pair,
  relative and indexed operands.
  Assumes clk, rst and ce of the flag unit; result one cycle after request.
*/
`timescale 1ns/1ps
`include "csf_map.svh"

module csf_addr_calc import csf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // request
  input wire logic req_valid,
  input wire csf_addr_req_t req,
  // answer
  output logic [15:0] ea_ff,
  output logic legal_ff,
  output logic done_ff
);

  logic [15:0] nxt_ea;
  logic nxt_legal;
  logic [15:0] sext_offs;

  assign sext_offs = {{8{req.offs[7]}}, req.offs[7:0]};

  // ********************************
  // address forming
  // ********************************
  always_comb begin
    nxt_ea = req.base;
    nxt_legal = 1'b1;
    unique case (req.mode)
      CSF_AM_PAIR_REG: begin
        nxt_legal = (req.base[15:8] == 8'h00) && !req.base[0]; // see (RULE20)
      end
      CSF_AM_PAIR_WORK: begin
        nxt_legal = (req.base[15:4] == 12'h000) && !req.base[0]; // see (RULE20)
      end
      CSF_AM_RELATIVE: begin
        // base is the address of the following instruction
        nxt_ea = req.base + sext_offs; // see (RULE21)
        nxt_legal = (req.offs[15:8] == {8{req.offs[7]}});
      end
      CSF_AM_INDEX_SHORT: begin
        nxt_ea = req.base + sext_offs; // see (RULE22)
        nxt_legal = !req.base[0] && (req.offs[15:8] == {8{req.offs[7]}});
      end
      CSF_AM_INDEX_LONG: begin
        nxt_ea = req.base + req.offs; // see (RULE22)
        nxt_legal = !req.base[0];
      end
      default: nxt_legal = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ea_ff <= 16'h0000;
      legal_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= req_valid;
      if (req_valid) begin
        ea_ff <= nxt_ea;
        legal_ff <= nxt_legal;
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  a_odd_pair_refused: assert property (@(posedge clk) disable iff (rst) // see (RULE20)
    ce && req_valid && req.mode == CSF_AM_PAIR_REG && req.base[0] |=> !legal_ff)
    else $error("odd register pair accepted");

  a_rel_sum: assert property (@(posedge clk) disable iff (rst) // see (RULE21)
    ce && req_valid && req.mode == CSF_AM_RELATIVE
    |=> ea_ff == $past(req.base) + {{8{$past(req.offs[7])}}, $past(req.offs[7:0])})
    else $error("relative address wrong");

endmodule // csf_addr_calc

// *** verilog/csf_flag_unit.sv ***
/*
  Status flag generation and the 8-bit condition status register of the CPU,
  with operand address checking for the datapath.
  Assumes the sequencer issues one operation per enabled cycle and that the
  register file port and the sequencer run on the same clock.
*/
`timescale 1ns/1ps
`include "csf_map.svh"

// Summary of operation
// (RULE1) carry set on carry out or borrow
// (RULE2) rotate and shift load carry with outgoing bit
// (RULE3) set, clear and invert carry commands
// (RULE4) zero set when arithmetic or logic result zero
// (RULE5) zero set when test or shift result zero
// (RULE6) sign copies result most significant bit
// (RULE7) overflow set on signed range excess
// (RULE8) logic operations clear overflow
// (RULE9) decimal bit records add or subtract
// (RULE10) half carry from bit 3 or borrow
// (RULE11) decimal adjust uses half carry, decimal bit
// (RULE12) fast status set on entry, cleared on return
// (RULE13) fast status blocks interrupts, selects fast return
// (RULE14) bank bit selects upper register bank
// (RULE15) bank commands clear or set bank bit
// (RULE16) flag update plus register write: undefined value
// (RULE17) status register writable by non-flag instructions
// (RULE18) only upper four bits feed jumps
// (RULE19) and updates zero, sign, overflow
// (RULE20) register pairs use even addresses only
// (RULE21) relative displacement added to next address
// (RULE22) short index signed, long index unsigned
// (RULE23) unaffected bits keep previous value
module csf_flag_unit import csf_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // operation from the sequencer
  input wire logic op_valid,
  input wire csf_op_t op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  // register file port
  input wire csf_reg_req_t reg_req,
  output logic [7:0] reg_rdata_ff,
  // operation result
  output logic [7:0] result_ff,
  output logic result_we_ff,
  output csf_flags_t flags_ff,
  // to jump logic and interrupt control
  output logic [3:0] cond_flags,
  output logic irq_block,
  output logic fast_return_ff,
  output logic bank_sel,
  // operand address checking
  input wire logic addr_valid,
  input wire csf_addr_req_t addr_req,
  output logic [15:0] addr_ea,
  output logic addr_legal,
  output logic addr_done
);

  csf_flags_t nxt_flags;
  logic [7:0] nxt_result;
  logic nxt_result_we;
  logic flag_upd;
  logic [8:0] wide;
  logic [4:0] low;
  logic cin;
  logic [7:0] corr;
  logic reg_hit_wr;
  logic reg_hit_rd;

  assign reg_hit_wr = reg_req.wr && (reg_req.addr == `CSF_STATUS_OFFSET);
  assign reg_hit_rd = reg_req.rd && (reg_req.addr == `CSF_STATUS_OFFSET);

  // ********************************
  // flag and result computation
  // ********************************
  always_comb begin
    nxt_flags = flags_ff; // see (RULE23)
    nxt_result = result_ff;
    nxt_result_we = 1'b0;
    flag_upd = 1'b0;
    wide = 9'h000;
    low = 5'h00;
    corr = 8'h00;
    cin = (op == CSF_OP_ADC || op == CSF_OP_SBC) ? flags_ff.c : 1'b0;
    if (op_valid) begin
      flag_upd = 1'b1;
      unique case (op)
        CSF_OP_ADD, CSF_OP_ADC: begin
          wide = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, cin};
          low = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
          nxt_result = wide[7:0];
          nxt_result_we = 1'b1;
          nxt_flags.c = wide[8]; // see (RULE1)
          nxt_flags.z = (wide[7:0] == 8'h00); // see (RULE4)
          nxt_flags.s = wide[7]; // see (RULE6)
          nxt_flags.v = (opnd_a[7] == opnd_b[7]) && (wide[7] != opnd_a[7]); // see (RULE7)
          nxt_flags.h = low[4]; // see (RULE10)
          nxt_flags.d = 1'b0; // see (RULE9)
        end
        CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CP: begin
          wide = {1'b0, opnd_a} - {1'b0, opnd_b} - {8'h00, cin};
          low = {1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} - {4'h0, cin};
          nxt_result = wide[7:0];
          nxt_result_we = (op != CSF_OP_CP);
          nxt_flags.c = wide[8]; // see (RULE1)
          nxt_flags.z = (wide[7:0] == 8'h00); // see (RULE4)
          nxt_flags.s = wide[7]; // see (RULE6)
          nxt_flags.v = (opnd_a[7] != opnd_b[7]) && (wide[7] != opnd_a[7]); // see (RULE7)
          if (op != CSF_OP_CP) begin
            // compare leaves the bcd bookkeeping alone
            nxt_flags.h = low[4]; // see (RULE10)
            nxt_flags.d = 1'b1; // see (RULE9)
          end
        end
        CSF_OP_INC, CSF_OP_DEC: begin
          wide[7:0] = (op == CSF_OP_INC) ? opnd_a + 8'h01 : opnd_a - 8'h01;
          nxt_result = wide[7:0];
          nxt_result_we = 1'b1;
          nxt_flags.z = (wide[7:0] == 8'h00); // see (RULE4)
          nxt_flags.s = wide[7]; // see (RULE6)
          nxt_flags.v = (op == CSF_OP_INC) ? (opnd_a == 8'h7F) : (opnd_a == 8'h80); // see (RULE7)
        end
        CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_COM: begin
          unique case (op)
            CSF_OP_AND: nxt_result = opnd_a & opnd_b;
            CSF_OP_OR: nxt_result = opnd_a | opnd_b;
            CSF_OP_XOR: nxt_result = opnd_a ^ opnd_b;
            default: nxt_result = ~opnd_a;
          endcase
          nxt_result_we = 1'b1;
          nxt_flags.z = (nxt_result == 8'h00); // see (RULE4) (RULE19)
          nxt_flags.s = nxt_result[7]; // see (RULE6) (RULE19)
          nxt_flags.v = 1'b0; // see (RULE8) (RULE19)
        end
        CSF_OP_RL, CSF_OP_RLC, CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
          unique case (op)
            CSF_OP_RL: wide = {opnd_a[7], opnd_a[6:0], opnd_a[7]};
            CSF_OP_RLC: wide = {opnd_a[7], opnd_a[6:0], flags_ff.c};
            CSF_OP_RR: wide = {opnd_a[0], opnd_a[0], opnd_a[7:1]};
            CSF_OP_RRC: wide = {opnd_a[0], flags_ff.c, opnd_a[7:1]};
            default: wide = {opnd_a[0], opnd_a[7], opnd_a[7:1]};
          endcase
          nxt_result = wide[7:0];
          nxt_result_we = 1'b1;
          nxt_flags.c = wide[8]; // see (RULE2)
          nxt_flags.z = (wide[7:0] == 8'h00); // see (RULE5)
          nxt_flags.s = wide[7]; // see (RULE6)
          // sign change through the shift counts as overflow
          nxt_flags.v = (op == CSF_OP_SRA) ? 1'b0 : (wide[7] != opnd_a[7]); // see (RULE7)
        end
        CSF_OP_TEST: begin
          // mask test: nothing written back
          nxt_result = opnd_a & opnd_b;
          nxt_flags.z = (nxt_result == 8'h00); // see (RULE5)
          nxt_flags.s = nxt_result[7]; // see (RULE6)
          nxt_flags.v = 1'b0; // see (RULE8)
        end
        CSF_OP_DA: begin
          if (!flags_ff.d) begin
            if (flags_ff.h || opnd_a[3:0] > `CSF_BCD_DIGIT_MAX) begin
              corr[3:0] = `CSF_BCD_CORR_DIGIT; // see (RULE11)
            end
            if (flags_ff.c || opnd_a > `CSF_BCD_BYTE_MAX) begin
              corr[7:4] = `CSF_BCD_CORR_DIGIT; // see (RULE11)
            end
            nxt_result = opnd_a + corr;
          end else begin
            if (flags_ff.h) begin
              corr[3:0] = `CSF_BCD_CORR_DIGIT; // see (RULE11)
            end
            if (flags_ff.c) begin
              corr[7:4] = `CSF_BCD_CORR_DIGIT; // see (RULE11)
            end
            nxt_result = opnd_a - corr;
          end
          nxt_result_we = 1'b1;
          nxt_flags.c = flags_ff.c || (corr[7:4] != 4'h0);
          nxt_flags.z = (nxt_result == 8'h00); // see (RULE4)
          nxt_flags.s = nxt_result[7]; // see (RULE6)
        end
        CSF_OP_SET_CARRY: nxt_flags.c = 1'b1; // see (RULE3)
        CSF_OP_CLEAR_CARRY: nxt_flags.c = 1'b0; // see (RULE3)
        CSF_OP_INVERT_CARRY: nxt_flags.c = ~flags_ff.c; // see (RULE3)
        CSF_OP_BANK_ZERO: nxt_flags.ba = 1'b0; // see (RULE15)
        CSF_OP_BANK_ONE: nxt_flags.ba = 1'b1; // see (RULE15)
        CSF_OP_FAST_ENTER: nxt_flags.fast_irq_active_bit = 1'b1; // see (RULE12)
        CSF_OP_INTERRUPT_RETURN_OP: nxt_flags.fast_irq_active_bit = 1'b0; // see (RULE12)
      endcase
    end
    if (reg_hit_wr) begin
      if (!flag_upd) begin
        nxt_flags = csf_flags_t'(reg_req.wdata); // see (RULE17)
      end else begin
        // clash gives an undefined value; op flags are ORed with the written bits that were clear before
        nxt_flags = nxt_flags | (csf_flags_t'(reg_req.wdata) & ~flags_ff); // see (RULE16)
      end
    end
  end

  // ********************************
  // status register
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= csf_flags_t'(`CSF_STATUS_RESET);
    end else if (ce) begin
      flags_ff <= nxt_flags;
    end
  end

  // ********************************
  // result and register read
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      result_ff <= 8'h00;
      result_we_ff <= 1'b0;
    end else if (ce) begin
      result_ff <= nxt_result;
      result_we_ff <= nxt_result_we;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (ce) begin
      reg_rdata_ff <= reg_hit_rd ? flags_ff : 8'h00;
    end
  end

  // ********************************
  // fast interrupt return
  // ********************************
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_return_ff <= 1'b0;
    end else if (ce) begin
      fast_return_ff <= op_valid && (op == CSF_OP_INTERRUPT_RETURN_OP) && flags_ff.fast_irq_active_bit; // see (RULE13)
    end
  end

  // decimal and half carry never reach the jump logic
  assign cond_flags = {flags_ff.c, flags_ff.z, flags_ff.s, flags_ff.v}; // see (RULE18)
  assign irq_block = flags_ff.fast_irq_active_bit; // see (RULE13)
  assign bank_sel = flags_ff.ba; // see (RULE14)

  // ********************************
  // operand addressing
  // ********************************
  csf_addr_calc u_addr (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req_valid(addr_valid),
    .req(addr_req),
    .ea_ff(addr_ea),
    .legal_ff(addr_legal),
    .done_ff(addr_done)
  );

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_add_issue;
    ce && op_valid && op == CSF_OP_ADD && !reg_hit_wr;
  endsequence

  sequence s_fast_enter;
    ce && op_valid && op == CSF_OP_FAST_ENTER;
  endsequence

  sequence s_interrupt_return_op_issue;
    ce && op_valid && op == CSF_OP_INTERRUPT_RETURN_OP;
  endsequence

  a_add_carry: assert property ( // see (RULE1)
    s_add_issue |=> flags_ff.c == $past(({1'b0, opnd_a} + {1'b0, opnd_b}) > 9'h0FF))
    else $error("add carry wrong");

  a_shift_carry: assert property ( // see (RULE2)
    ce && op_valid && op == CSF_OP_RR && !reg_hit_wr |=> flags_ff.c == $past(opnd_a[0]))
    else $error("rotate carry wrong");

  a_carry_cmd_keep: assert property ( // see (RULE3)
    ce && op_valid && op == CSF_OP_INVERT_CARRY && !reg_hit_wr
    |=> flags_ff.c != $past(flags_ff.c) && flags_ff[6:0] == $past(flags_ff[6:0]))
    else $error("carry command disturbed flags");

  a_zero_sign: assert property ( // see (RULE4) (RULE6)
    ce && op_valid && op inside {CSF_OP_ADD, CSF_OP_AND, CSF_OP_XOR} && !reg_hit_wr
    |=> flags_ff.z == (result_ff == 8'h00) && flags_ff.s == result_ff[7])
    else $error("zero or sign wrong");

  a_logic_ovf: assert property ( // see (RULE8)
    ce && op_valid && op == CSF_OP_OR && !reg_hit_wr |=> !flags_ff.v)
    else $error("logic left overflow set");

  a_sub_dec: assert property ( // see (RULE9)
    ce && op_valid && op == CSF_OP_SUB && !reg_hit_wr ##1 ce && op_valid && op == CSF_OP_ADD
    && !reg_hit_wr |-> flags_ff.d ##1 !flags_ff.d)
    else $error("decimal bit not tracking");

  a_fast_cycle: assert property ( // see (RULE12) (RULE13)
    s_fast_enter ##1 (!(ce && op_valid && op == CSF_OP_INTERRUPT_RETURN_OP) && !reg_hit_wr)[*2]
    ##1 s_interrupt_return_op_issue |=> fast_return_ff && !irq_block)
    else $error("fast return path wrong");

  a_bank_one: assert property ( // see (RULE15)
    ce && op_valid && op == CSF_OP_BANK_ONE && !reg_hit_wr |=> bank_sel)
    else $error("bank select not set");

  a_direct_write: assert property ( // see (RULE17)
    ce && !op_valid && reg_hit_wr |=> flags_ff == $past(reg_req.wdata))
    else $error("direct write lost");

  a_idle_hold: assert property ( // see (RULE23)
    !ce || (!op_valid && !reg_hit_wr) |=> $stable(flags_ff))
    else $error("flags changed while idle");

  a_half_carry: assert property ( // see (RULE10)
    s_add_issue |=> flags_ff.h == $past(({1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]}) > 5'h0F))
    else $error("half carry wrong");

  a_add_ovf: assert property ( // see (RULE7)
    s_add_issue |=> flags_ff.v == ($past(opnd_a[7]) == $past(opnd_b[7])
    && result_ff[7] != $past(opnd_a[7])))
    else $error("add overflow wrong");

  a_shift_zero: assert property ( // see (RULE5)
    ce && op_valid && op == CSF_OP_SRA && !reg_hit_wr |=> flags_ff.z == ($past(opnd_a[7:1]) == 7'h00))
    else $error("shift zero wrong");

  a_fast_enter: assert property ( // see (RULE12)
    ce && op_valid && op == CSF_OP_FAST_ENTER && !reg_hit_wr |=> irq_block)
    else $error("fast status not set");

endmodule // csf_flag_unit

// *** sim/csf_seq_model.sv ***
/*
  Behavioural model of the instruction sequencer and interrupt control that
  issue operations to the status flag logic.
  Assumes the bench changes cmd_* just after a rising clock edge.
*/
`timescale 1ns/1ps

module csf_seq_model import csf_pkg::*; (
  // request from the bench
  input wire logic cmd_valid,
  input wire csf_op_t cmd_op,
  input wire logic [7:0] cmd_a,
  input wire logic [7:0] cmd_b,
  // status from the flag unit
  input wire logic irq_block,
  // operation port of the flag unit
  output logic op_valid,
  output csf_op_t op,
  output logic [7:0] opnd_a,
  output logic [7:0] opnd_b
);
  // a blocked fast interrupt is never entered twice
  assign op_valid = cmd_valid && !(cmd_op == CSF_OP_FAST_ENTER && irq_block);
  // released operands show garbage, never the last value
  assign op = cmd_op;
  assign opnd_a = cmd_valid ? cmd_a : ~cmd_a;
  assign opnd_b = cmd_valid ? cmd_b : ~cmd_b;
endmodule // csf_seq_model

// *** sim/tb.sv ***
/*
  Self-checking bench of the status flag unit: corner cases, a seeded random
  operation stream, status register access and operand address checks.
  Assumes csf_map.svh on the include path and the package compiled first.
*/
`timescale 1ns/1ps
`include "csf_map.svh"

module tb import csf_pkg::*;;
  logic clk, rst, ce, cmd_valid, op_valid, addr_valid;
  csf_op_t cmd_op, op;
  logic [7:0] cmd_a, cmd_b, opnd_a, opnd_b, reg_rdata_ff, result_ff;
  logic [3:0] cond_flags;
  logic [15:0] addr_ea;
  logic result_we_ff, irq_block, fast_return_ff, bank_sel, addr_legal, addr_done;
  csf_reg_req_t reg_req;
  csf_addr_req_t addr_req;
  csf_flags_t flags_ff, exp_f;
  int n_errors, n_compared;
  integer seed;

  csf_seq_model u_csf_seq_model (.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_a(cmd_a),
    .cmd_b(cmd_b), .irq_block(irq_block), .op_valid(op_valid), .op(op), .opnd_a(opnd_a),
    .opnd_b(opnd_b));

  csf_flag_unit u_csf_flag_unit (.clk(clk), .rst(rst), .ce(ce), .op_valid(op_valid),
    .op(op), .opnd_a(opnd_a), .opnd_b(opnd_b), .reg_req(reg_req),
    .reg_rdata_ff(reg_rdata_ff), .result_ff(result_ff), .result_we_ff(result_we_ff),
    .flags_ff(flags_ff), .cond_flags(cond_flags), .irq_block(irq_block),
    .fast_return_ff(fast_return_ff), .bank_sel(bank_sel), .addr_valid(addr_valid),
    .addr_req(addr_req), .addr_ea(addr_ea), .addr_legal(addr_legal), .addr_done(addr_done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ********************************
  // helpers
  // ********************************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // expected {writeback, result, flags}
  function automatic logic [16:0] model(csf_op_t o, logic [7:0] a, logic [7:0] b,
                                        csf_flags_t f);
    logic [8:0] t;
    logic [7:0] r, corr;
    logic we, hz, cin, hi, lo;
    csf_flags_t n;
    n = f;
    r = 8'h00;
    we = 1'b1;
    hz = 1'b1;
    cin = (o == CSF_OP_ADC || o == CSF_OP_SBC) && f.c;
    case (o)
      CSF_OP_ADD, CSF_OP_ADC: begin
        t = {1'b0, a} + {1'b0, b} + 9'(cin);
        r = t[7:0];
        n.c = t[8];
        n.d = 1'b0;
        n.h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin)) > 5'h0F;
        n.v = (a[7] == b[7]) && (r[7] != a[7]);
      end
      CSF_OP_SUB, CSF_OP_SBC, CSF_OP_CP: begin
        t = {1'b0, a} - {1'b0, b} - 9'(cin);
        r = t[7:0];
        n.c = t[8];
        n.v = (a[7] != b[7]) && (r[7] != a[7]);
        if (o == CSF_OP_CP) we = 1'b0;
        else begin
          n.d = 1'b1;
          n.h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + 5'(cin));
        end
      end
      CSF_OP_INC: begin r = a + 8'h01; n.v = a == 8'h7F; end
      CSF_OP_DEC: begin r = a - 8'h01; n.v = a == 8'h80; end
      CSF_OP_AND: begin r = a & b; n.v = 1'b0; end
      CSF_OP_OR: begin r = a | b; n.v = 1'b0; end
      CSF_OP_XOR: begin r = a ^ b; n.v = 1'b0; end
      CSF_OP_COM: begin r = ~a; n.v = 1'b0; end
      CSF_OP_TEST: begin r = a & b; n.v = 1'b0; we = 1'b0; end
      CSF_OP_RL, CSF_OP_RLC: begin
        r = {a[6:0], (o == CSF_OP_RL) ? a[7] : f.c};
        n.c = a[7];
        n.v = r[7] ^ a[7];
      end
      CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
        r = {(o == CSF_OP_RR) ? a[0] : (o == CSF_OP_RRC) ? f.c : a[7], a[7:1]};
        n.c = a[0];
        n.v = r[7] ^ a[7];
      end
      CSF_OP_DA: begin
        hi = f.c || (!f.d && a > 8'h99);
        lo = f.h || (!f.d && a[3:0] > 4'h9);
        corr = {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
        r = f.d ? a - corr : a + corr;
        n.c = hi;
      end
      default: begin
        we = 1'b0;
        hz = 1'b0;
        case (o)
          CSF_OP_SET_CARRY: n.c = 1'b1;
          CSF_OP_CLEAR_CARRY: n.c = 1'b0;
          CSF_OP_INVERT_CARRY: n.c = ~f.c;
          CSF_OP_BANK_ZERO: n.ba = 1'b0;
          CSF_OP_BANK_ONE: n.ba = 1'b1;
          CSF_OP_FAST_ENTER: n.fast_irq_active_bit = 1'b1;
          default: n.fast_irq_active_bit = 1'b0;
        endcase
      end
    endcase
    if (hz) begin
      n.z = r == 8'h00;
      n.s = r[7];
    end
    return {we, r, n};
  endfunction

  task automatic check_state();
    chk({8'h00, flags_ff}, {8'h00, exp_f});
    chk({12'h000, cond_flags}, {12'h000, exp_f[7:4]});
    chk({15'h0, irq_block}, {15'h0, exp_f.fast_irq_active_bit});
    chk({15'h0, bank_sel}, {15'h0, exp_f.ba});
  endtask

  // back to back: cmd_valid stays up between calls
  task automatic do_op(csf_op_t o, logic [7:0] a, logic [7:0] b);
    logic [16:0] m;
    logic acc, fr;
    acc = !(o == CSF_OP_FAST_ENTER && exp_f.fast_irq_active_bit);
    fr = o == CSF_OP_INTERRUPT_RETURN_OP && exp_f.fast_irq_active_bit;
    m = model(o, a, b, exp_f);
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_a = a;
    cmd_b = b;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
    tick();
    if (acc) exp_f = m[7:0];
    chk({15'h0, fast_return_ff}, {15'h0, fr});
    chk({15'h0, result_we_ff}, {15'h0, acc && m[16]});
    if (acc && m[16]) chk({8'h00, result_ff}, {8'h00, m[15:8]});
    check_state();
  endtask

  task automatic reg_acc(logic wr, logic [7:0] addr, logic [7:0] data);
    cmd_valid = 1'b0;
    reg_req = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    tick();
    if (wr && addr == `CSF_STATUS_OFFSET) exp_f = data;
    if (!wr) chk({8'h00, reg_rdata_ff}, (addr == `CSF_STATUS_OFFSET) ? {8'h00, exp_f} : 16'h0000);
    check_state();
  endtask

  task automatic addr_chk(csf_amode_t md, logic [15:0] base, logic [15:0] offs, logic legal,
                          logic [15:0] ea);
    addr_valid = 1'b1;
    addr_req = '{mode: md, base: base, offs: offs};
    tick();
    chk({15'h0, addr_done}, 16'h0001);
    chk({15'h0, addr_legal}, {15'h0, legal});
    if (legal && md > CSF_AM_PAIR_WORK) chk(addr_ea, ea);
  endtask

  task automatic do_reset();
    cmd_valid = 1'b0;
    addr_valid = 1'b0;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    exp_f = `CSF_STATUS_RESET;
    chk({14'h0, result_we_ff, fast_return_ff}, 16'h0000);
    chk({15'h0, addr_done}, 16'h0000);
    check_state();
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    seed = 32'h345E;
    n_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = CSF_OP_ADD;
    cmd_a = 8'h00;
    cmd_b = 8'h00;
    addr_valid = 1'b0;
    addr_req = '0;
    reg_req = '0;
    exp_f = '0;
    #1;
    do_reset();
    do_op(CSF_OP_ADD, 8'h7F, 8'h01);
    do_op(CSF_OP_AND, 8'hF0, 8'h0F);
    do_op(CSF_OP_ADD, 8'hFF, 8'h01);
    do_op(CSF_OP_SUB, 8'h80, 8'h01);
    do_op(CSF_OP_SUB, 8'h00, 8'h01);
    do_op(CSF_OP_ADD, 8'h09, 8'h08);
    do_op(CSF_OP_DA, 8'h11, 8'h00);
    do_op(CSF_OP_ADD, 8'h90, 8'h90);
    do_op(CSF_OP_DA, 8'h20, 8'h00);
    do_op(CSF_OP_SUB, 8'h20, 8'h01);
    do_op(CSF_OP_DA, 8'h1F, 8'h00);
    do_op(CSF_OP_INC, 8'h7F, 8'h00);
    do_op(CSF_OP_DEC, 8'h80, 8'h00);
    do_op(CSF_OP_XOR, 8'h5A, 8'h5A);
    do_op(CSF_OP_RL, 8'h80, 8'h00);
    do_op(CSF_OP_RRC, 8'h01, 8'h00);
    do_op(CSF_OP_SRA, 8'h01, 8'h00);
    do_op(CSF_OP_TEST, 8'h55, 8'hAA);
    do_op(CSF_OP_SET_CARRY, 8'h00, 8'h00);
    do_op(CSF_OP_INVERT_CARRY, 8'h00, 8'h00);
    do_op(CSF_OP_INVERT_CARRY, 8'h00, 8'h00);
    do_op(CSF_OP_CLEAR_CARRY, 8'h00, 8'h00);
    do_op(CSF_OP_BANK_ONE, 8'h00, 8'h00);
    do_op(CSF_OP_BANK_ZERO, 8'h00, 8'h00);
    do_op(CSF_OP_FAST_ENTER, 8'h00, 8'h00);
    do_op(CSF_OP_FAST_ENTER, 8'h00, 8'h00);
    do_op(CSF_OP_BANK_ONE, 8'h00, 8'h00);
    do_op(CSF_OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00);
    do_op(CSF_OP_INTERRUPT_RETURN_OP, 8'h00, 8'h00);
    reg_acc(1'b1, 8'hD5, 8'hA5);
    reg_acc(1'b0, 8'hD5, 8'h00);
    reg_acc(1'b1, 8'hD4, 8'h3C);
    reg_acc(1'b0, 8'hD4, 8'h00);
    // frozen cycle: nothing may move
    ce = 1'b0;
    cmd_valid = 1'b1;
    cmd_op = CSF_OP_BANK_ZERO;
    tick();
    ce = 1'b1;
    check_state();
    for (int i = 0; i < 400; i++) begin
      if ($random(seed) % 6 == 0) reg_acc(1'b1, 8'hD5, 8'($random(seed)));
      else do_op(csf_op_t'(5'(($random(seed) & 32'h7FFF_FFFF) % 25)), 8'($random(seed)),
                 8'($random(seed)));
    end
    addr_chk(CSF_AM_PAIR_REG, 16'h00FE, 16'h0000, 1'b1, 16'h0000);
    addr_chk(CSF_AM_PAIR_REG, 16'h00FF, 16'h0000, 1'b0, 16'h0000);
    addr_chk(CSF_AM_PAIR_REG, 16'h0100, 16'h0000, 1'b0, 16'h0000);
    addr_chk(CSF_AM_PAIR_WORK, 16'h000E, 16'h0000, 1'b1, 16'h0000);
    addr_chk(CSF_AM_PAIR_WORK, 16'h0010, 16'h0000, 1'b0, 16'h0000);
    addr_chk(CSF_AM_RELATIVE, 16'h1000, 16'hFFFE, 1'b1, 16'h0FFE);
    addr_chk(CSF_AM_RELATIVE, 16'h1000, 16'h007F, 1'b1, 16'h107F);
    addr_chk(CSF_AM_RELATIVE, 16'h1000, 16'h0080, 1'b0, 16'h0000);
    addr_chk(CSF_AM_INDEX_SHORT, 16'h0004, 16'hFF80, 1'b1, 16'hFF84);
    addr_chk(CSF_AM_INDEX_SHORT, 16'h0005, 16'h0001, 1'b0, 16'h0000);
    addr_chk(CSF_AM_INDEX_LONG, 16'h0002, 16'hFFFF, 1'b1, 16'h0001);
    do_reset();
    report_and_stop();
  end
endmodule // tb
